//--- crh_pkg.sv
package crh_pkg;
   // ************************************************************
   // Record layout
   // ************************************************************
   localparam int BASE_HDR_BYTES = 16;
   localparam int APP_HDR_BYTES = 8;
   localparam int TYPE_MORE_BIT = 7;
   localparam int CODE_W = 7;
   localparam int LEN_W = 16;
   // Record codes.
   localparam logic [6:0] OLD_STYLE_RECORD_CODE = 7'h00;
   localparam logic [6:0] HDLC_POS_CODE = 7'h01;
   localparam logic [6:0] ETHERNET_RECORD_CODE = 7'h02;
   localparam logic [6:0] ATM_CODE = 7'h03;
   localparam logic [6:0] AAL5_CODE = 7'h04;
   localparam logic [6:0] MC_FIRST_CODE = 7'h05;
   localparam logic [6:0] MC_LAST_CODE = 7'h09;
   localparam logic [6:0] COLOUR_HDLC_CODE = 7'h0A;
   localparam logic [6:0] COLOUR_ETH_CODE = 7'h0B;
   localparam logic [6:0] MC_AAL2_CODE = 7'h0C;
   localparam logic [6:0] TCP_FLOW_CODE = 7'h0E;
   localparam logic [6:0] DIST_HDLC_CODE = 7'h0F;
   localparam logic [6:0] DIST_ETH_CODE = 7'h10;
   localparam logic [6:0] COLOUR_MC_HDLC_CODE = 7'h11;
   localparam logic [6:0] AAL2_CODE = 7'h12;
   localparam logic [6:0] HASH_POS_CODE = 7'h13;
   localparam logic [6:0] HASH_ETH_CODE = 7'h14;
   localparam logic [6:0] INFINIBAND_CODE = 7'h15;
   localparam logic [6:0] RAW_LINK_CODE = 7'h18;
   localparam logic [6:0] RSVD_FIRST_CODE = 7'h20;
   localparam logic [6:0] RSVD_LAST_CODE = 7'h2F;
   localparam logic [6:0] PAD_CODE = 7'h30;
   localparam logic [6:0] CLASSIFY_HDR_CODE = 7'h03;
   // Classification header field positions.
   localparam int CH_MORE = 63;
   localparam int CH_TYPE_HI = 62;
   localparam int CH_TYPE_LO = 56;
   localparam int CH_HIT = 55;
   localparam int CH_MULTI = 54;
   localparam int CH_USER_HI = 51;
   localparam int CH_USER_LO = 36;
   localparam int CH_DROP = 34;
   localparam int CH_STREAM_HI = 33;
   localparam int CH_STREAM_LO = 32;
   // Lookup memory word field positions.
   localparam int MW_TAG_HI = 19;
   localparam int MW_TAG_LO = 4;
   localparam int MW_DROP = 2;
   localparam int MW_STREAM_HI = 1;
   localparam int MW_STREAM_LO = 0;
   // Register map.
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] COUNT_ADDR = 12'h008;
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_SEQ_BIT = 1;
   localparam int CTRL_XTRA_HI = 5;
   localparam int CTRL_XTRA_LO = 2;
   localparam logic [31:0] CTRL_RESET = 32'h00000002;
   localparam int RLEN_LSB = 16;
endpackage : crh_pkg

//--- crh_code_check.sv
`timescale 1ns/100ps
module crh_code_check
   import crh_pkg::*;
(
   // Code in.
   input wire logic [6:0] code,
   // Classification.
   output logic reserved,
   output logic colour
);
   always_comb
   begin
      reserved = (code >= RSVD_FIRST_CODE) && (code <= RSVD_LAST_CODE); // [R11]
      colour = (code == COLOUR_HDLC_CODE) || (code == COLOUR_ETH_CODE) ||
               (code == COLOUR_MC_HDLC_CODE) || (code == DIST_HDLC_CODE) ||
               (code == DIST_ETH_CODE) || (code == HASH_POS_CODE) ||
               (code == HASH_ETH_CODE); // [R8] [R9] [R10]
   end
endmodule : crh_code_check

//--- crh_apb_regs.sv
`timescale 1ns/100ps
module crh_apb_regs
   import crh_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Register contents.
   output logic [31:0] ctrl,
   input wire logic [31:0] status,
   input wire logic [31:0] count
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } crh_regs_type;
   crh_regs_type r;
   crh_regs_type next_r;

   // ************************************************************
   // Single wait state slave.
   // ************************************************************
   always_comb
   begin
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      if (psel && penable && !r.pready)
      begin
         next_r.pready = 1'b1;
         next_r.prdata = 32'h00000000;
         case (paddr)
            CTRL_ADDR:
            begin
               if (pwrite)
                  next_r.ctrl = pwdata;
               else
                  next_r.prdata = r.ctrl;
            end
            STATUS_ADDR: next_r.prdata = pwrite ? 32'h00000000 : status;
            COUNT_ADDR: next_r.prdata = pwrite ? 32'h00000000 : count;
            default: next_r.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= '{ctrl: CTRL_RESET, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
      else
         r <= next_r;
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign ctrl = r.ctrl;
endmodule : crh_apb_regs

//--- crh_framer.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// R1 - Type byte bit 7 set when any appended header follows, else clear.
// R2 - Low seven type bits hold the record code; InfiniBand uses 21.
// R3 - InfiniBand payload equals length minus 16 minus appended header bytes.
// R4 - Each appended header is exactly eight bytes long.
// R5 - Appended header bit 7 says another appended header follows.
// R6 - Classification header has code 3 and is attached to InfiniBand records.
// R7 - Record codes follow the fixed code table, padding is 48.
// R8 - Codes 10, 11, 17 reuse the loss counter as colour.
// R9 - Codes 15, 16 reuse the loss counter as distribution colour.
// R10 - Codes 19, 20 are hash balanced coloured records.
// R11 - Codes 32 to 47 are never emitted.
// R12 - Classification fields come from card metadata or lookup memory.
// R13 - Classification: more at 63, code 62:56, hit 55, multi hit 54.
// R14 - Classification: user 51:36, drop 34, stream 33:32, sequence 31:0.
// R15 - Length field gives whole record bytes to the next record start.
// R16 - The last appended header always has its more bit clear.
module crh_framer
   import crh_pkg::*;
#(
   parameter int XTRA_MAX = 15
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Record request from the capture front end.
   input wire logic req_valid,
   input wire logic [6:0] req_code,
   input wire logic [15:0] req_payload_len,
   input wire logic [15:0] req_loss_counter_field,
   input wire logic [15:0] req_colour,
   input wire logic req_hit,
   input wire logic req_multi_hit,
   input wire logic [15:0] meta_user,
   input wire logic meta_drop,
   input wire logic [1:0] meta_stream,
   input wire logic [31:0] mem_word,
   input wire logic [31:0] seq_num,
   // Header output, one 64-bit word per cycle.
   output logic hdr_valid,
   output logic [63:0] hdr_data,
   output logic hdr_last,
   output logic req_ready,
   output logic req_refused
);
   typedef enum {IDLE, BASE0, BASE1, XTRA, CLASS} crh_state_type;
   typedef struct packed {
      crh_state_type state;
      logic [6:0] code;
      logic [15:0] rlen;
      logic [15:0] lctr;
      logic [3:0] xtra_left;
      logic [63:0] class_word;
      logic hdr_valid;
      logic [63:0] hdr_data;
      logic hdr_last;
      logic req_ready;
      logic req_refused;
      logic [31:0] records;
      logic [31:0] refused;
      logic [6:0] last_code;
   } crh_frm_type;
   crh_frm_type r;
   crh_frm_type next_r;

   logic [31:0] ctrl;
   logic code_reserved;
   logic code_colour;
   logic is_ib;
   logic [3:0] xtra_cnt;
   logic [4:0] hdr_total;
   logic [63:0] class_word;
   logic [15:0] user_bits;
   logic drop_bit;
   logic [1:0] stream_bits;

   // ************************************************************
   // Register slave and code table.
   // ************************************************************
   crh_apb_regs crh_apb_regs_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl(ctrl),
      .status({r.refused[15:0], 9'h000, r.last_code}),
      .count(r.records)
   );

   crh_code_check crh_code_check_inst (
      .code(req_code),
      .reserved(code_reserved),
      .colour(code_colour)
   );

   // ************************************************************
   // Header assembly.
   // ************************************************************
   always_comb
   begin
      is_ib = (req_code == INFINIBAND_CODE); // [R2] [R6]
      xtra_cnt = ctrl[CTRL_XTRA_HI:CTRL_XTRA_LO];
      if (xtra_cnt > 4'(XTRA_MAX))
         xtra_cnt = 4'(XTRA_MAX);
      hdr_total = 5'(xtra_cnt) + (is_ib ? 5'h01 : 5'h00);
      // Classification source selected by software; the lookup word
      // wins only when the search actually hit, otherwise metadata.
      if (ctrl[CTRL_SRC_BIT] && req_hit) // [R12]
      begin
         user_bits = mem_word[MW_TAG_HI:MW_TAG_LO];
         drop_bit = mem_word[MW_DROP];
         stream_bits = mem_word[MW_STREAM_HI:MW_STREAM_LO];
      end
      else
      begin
         user_bits = meta_user;
         drop_bit = meta_drop;
         stream_bits = meta_stream;
      end
      class_word = 64'h0000000000000000;
      class_word[CH_MORE] = 1'b0; // [R16]
      class_word[CH_TYPE_HI:CH_TYPE_LO] = CLASSIFY_HDR_CODE; // [R13]
      class_word[CH_HIT] = req_hit; // [R13]
      class_word[CH_MULTI] = req_multi_hit; // [R13]
      class_word[CH_USER_HI:CH_USER_LO] = user_bits; // [R14]
      class_word[CH_DROP] = drop_bit; // [R14]
      class_word[CH_STREAM_HI:CH_STREAM_LO] = stream_bits; // [R14]
      class_word[31:0] = ctrl[CTRL_SEQ_BIT] ? seq_num : 32'h00000000; // [R14]

      next_r = r;
      next_r.hdr_valid = 1'b0;
      next_r.hdr_last = 1'b0;
      next_r.req_refused = 1'b0;
      case (r.state)
         IDLE:
         begin
            next_r.req_ready = 1'b1;
            if (req_valid && r.req_ready)
            begin
               next_r.req_ready = 1'b0;
               if (code_reserved) // [R11]
               begin
                  next_r.req_refused = 1'b1;
                  next_r.refused = r.refused + 32'h00000001;
               end
               else
               begin
                  next_r.state = BASE0;
                  next_r.code = req_code; // [R7]
                  next_r.xtra_left = xtra_cnt;
                  next_r.class_word = class_word;
                  next_r.class_word[CH_MORE] = 1'b0; // [R16]
                  // Length covers base, every appended header and payload.
                  next_r.rlen = 16'(BASE_HDR_BYTES) + 16'(APP_HDR_BYTES) * 16'(hdr_total)
                                + req_payload_len; // [R3] [R4] [R15]
                  next_r.lctr = code_colour ? req_colour : req_loss_counter_field; // [R8] [R9] [R10]
               end
            end
         end
         BASE0:
         begin
            // Word 0 carries the type byte in its low byte.
            next_r.hdr_valid = 1'b1;
            next_r.hdr_data = 64'h0000000000000000;
            next_r.hdr_data[CODE_W-1:0] = r.code; // [R2]
            next_r.hdr_data[TYPE_MORE_BIT] = (r.xtra_left != 4'h0) ||
                                            (r.code == INFINIBAND_CODE); // [R1]
            next_r.state = BASE1;
         end
         BASE1:
         begin
            next_r.hdr_valid = 1'b1;
            next_r.hdr_data = 64'h0000000000000000;
            next_r.hdr_data[RLEN_LSB +: LEN_W] = r.rlen; // [R15]
            next_r.hdr_data[LEN_W-1:0] = r.lctr; // [R8]
            if (r.xtra_left != 4'h0)
               next_r.state = XTRA;
            else if (r.code == INFINIBAND_CODE)
               next_r.state = CLASS;
            else
            begin
               next_r.hdr_last = 1'b1;
               next_r.state = IDLE;
            end
         end
         XTRA:
         begin
            // Padding headers of code 0 that carry only the chain bit.
            next_r.hdr_valid = 1'b1;
            next_r.hdr_data = 64'h0000000000000000;
            next_r.xtra_left = r.xtra_left - 4'h1;
            next_r.hdr_data[CH_MORE] = (r.xtra_left != 4'h1) ||
                                       (r.code == INFINIBAND_CODE); // [R5] [R16]
            if (r.xtra_left != 4'h1)
               next_r.state = XTRA;
            else if (r.code == INFINIBAND_CODE)
               next_r.state = CLASS;
            else
            begin
               next_r.hdr_last = 1'b1;
               next_r.state = IDLE;
            end
         end
         CLASS:
         begin
            next_r.hdr_valid = 1'b1;
            next_r.hdr_data = r.class_word; // [R6] [R16]
            next_r.hdr_last = 1'b1;
            next_r.state = IDLE;
         end
         default: next_r.state = IDLE;
      endcase
      if (next_r.hdr_last)
      begin
         next_r.records = r.records + 32'h00000001;
         next_r.last_code = r.code;
      end
   end

   // ************************************************************
   // State register.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.state <= IDLE;
      end
      else
         r <= next_r;
   end

   // ************************************************************
   // Outputs, all taken straight from the state register.
   // ************************************************************
   assign hdr_valid = r.hdr_valid;
   assign hdr_data = r.hdr_data;
   assign hdr_last = r.hdr_last;
   assign req_ready = r.req_ready;
   assign req_refused = r.req_refused;
endmodule : crh_framer

//--- crh_framer_chk.sv
`timescale 1ns/100ps
// ************************************************************
// Header chain checker
// ************************************************************
module crh_framer_chk
   import crh_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Record request.
   input wire logic req_valid,
   input wire logic [6:0] req_code,
   input wire logic [15:0] req_payload_len,
   input wire logic req_ready,
   input wire logic req_refused,
   // Header words.
   input wire logic hdr_valid,
   input wire logic [63:0] hdr_data,
   input wire logic hdr_last
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [4:0] idx;
   logic [6:0] code_l;
   logic [15:0] pay_l, rlen_l;
   logic more_l, take, rsv;
   int rl;
   assign take = req_valid && req_ready;
   assign rsv = req_code inside {[RSVD_FIRST_CODE:RSVD_LAST_CODE]};
   assign rl = (idx == 5'h01) ? int'(hdr_data[31:16]) : int'(rlen_l);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idx <= 5'h00;
      else if (hdr_valid)
         idx <= hdr_last ? 5'h00 : idx + 5'h01;
   end
   // Request fields are held at the take and header fields from the word carrying them, so the last word can be judged whole.
   always_ff @(posedge pclk)
   begin
      if (take)
      begin
         code_l <= req_code;
         pay_l <= req_payload_len;
      end
      if (hdr_valid && idx == 5'h00)
         more_l <= hdr_data[TYPE_MORE_BIT];
      if (hdr_valid && idx == 5'h01)
         rlen_l <= hdr_data[31:16];
   end
   property p_refuse;
      take && rsv |=> req_refused && !hdr_valid ##1 !hdr_valid [*2];
   endproperty
   a_refuse: assert property (p_refuse) else $error("reserved code not refused");
   property p_code;
      take && !rsv |-> ##2 hdr_valid && hdr_data[6:0] == $past(req_code, 2);
   endproperty
   a_code: assert property (p_code) else $error("record code wrong");
   property p_ib_more;
      take && req_code == INFINIBAND_CODE |-> ##2 hdr_data[TYPE_MORE_BIT];
   endproperty
   a_ib_more: assert property (p_ib_more) else $error("no header flag");
   property p_more;
      hdr_valid && hdr_last |-> more_l == (idx >= 5'h02);
   endproperty
   a_more: assert property (p_more) else $error("type bit 7 wrong");
   property p_chain;
      hdr_valid && idx >= 5'h02 && !hdr_last |-> hdr_data[CH_MORE];
   endproperty
   a_chain: assert property (p_chain) else $error("chain broken");
   property p_end;
      hdr_valid && hdr_last && idx >= 5'h02 |-> !hdr_data[CH_MORE];
   endproperty
   a_end: assert property (p_end) else $error("chain not ended");
   property p_class;
      hdr_valid && hdr_last && code_l == INFINIBAND_CODE
         |-> idx >= 5'h02 && hdr_data[CH_TYPE_HI:CH_TYPE_LO] == CLASSIFY_HDR_CODE;
   endproperty
   a_class: assert property (p_class) else $error("class header missing");
   property p_len;
      hdr_valid && hdr_last
         |-> rl == BASE_HDR_BYTES + APP_HDR_BYTES * (int'(idx) - 1) + int'(pay_l);
   endproperty
   a_len: assert property (p_len) else $error("record length wrong");
   c_refuse: cover property (take && rsv);
   c_chain: cover property (hdr_valid && idx >= 5'h02 && !hdr_last);
   c_class: cover property (hdr_valid && hdr_last && code_l == INFINIBAND_CODE);
endmodule : crh_framer_chk

bind crh_framer crh_framer_chk crh_framer_chk_inst (
   .pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_code(req_code),
   .req_payload_len(req_payload_len), .req_ready(req_ready), .req_refused(req_refused),
   .hdr_valid(hdr_valid), .hdr_data(hdr_data), .hdr_last(hdr_last));

//--- crh_host_reader.sv
`timescale 1ns/100ps
// ************************************************************
// Host record reader
// ************************************************************
module crh_host_reader
   import crh_pkg::*;
(
   // Clock, reset and clear.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   // Header words.
   input wire logic hdr_valid,
   input wire logic [63:0] hdr_data,
   input wire logic hdr_last,
   // Parsed record.
   output logic [63:0] words [0:19],
   output logic [4:0] nw,
   output logic got,
   output logic chain_ok,
   output logic [15:0] payload
);
   // Software takes the payload from the length field less the header words received.
   assign payload = words[1][31:16] - 16'(BASE_HDR_BYTES + APP_HDR_BYTES * (int'(nw) - 2));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nw <= 5'h00;
         got <= 1'b0;
         chain_ok <= 1'b1;
      end
      else if (clr)
      begin
         nw <= 5'h00;
         got <= 1'b0;
         chain_ok <= 1'b1;
      end
      else if (hdr_valid)
      begin
         words[nw] <= hdr_data;
         nw <= nw + 5'h01;
         got <= hdr_last;
         // From word 2 on, the more bit must be set on every word but the last.
         if (nw >= 5'h02 && hdr_data[CH_MORE] == hdr_last)
            chain_ok <= 1'b0;
      end
   end
endmodule : crh_host_reader

//--- capture_record_header_chain_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); end end
// ************************************************************
// Testbench
// ************************************************************
module capture_record_header_chain_tb_top
   import crh_pkg::*;
;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic req_valid = 1'b0, req_hit = 1'b0, req_multi_hit = 1'b0, meta_drop = 1'b1, clr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, mem_word = 32'h000BEEF5, seq_num = 32'h12345678;
   logic [6:0] req_code = 7'h00;
   logic [15:0] req_payload_len = 16'h0, req_loss_counter_field = 16'h0, req_colour = 16'h0;
   logic [15:0] meta_user = 16'hA5C3, payload;
   logic [1:0] meta_stream = 2'h2;
   logic [63:0] hdr_data, cls;
   logic [63:0] words [0:19];
   logic [4:0] nw;
   logic hdr_valid, hdr_last, req_ready, req_refused, got, chain_ok, err, ref_seen, src;
   logic [6:0] codes [0:21] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h09, 7'h0A,
      7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h16, 7'h17,
      7'h18, 7'h30};
   logic [31:0] cv [0:2] = '{32'h02, 32'h0B, 32'h3D};
   logic hv [0:2] = '{1'b0, 1'b1, 1'b0};
   int error_cnt = 0, compares = 0;
   crh_framer #(.XTRA_MAX(15)) crh_framer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_code(req_code),
      .req_payload_len(req_payload_len), .req_loss_counter_field(req_loss_counter_field),
      .req_colour(req_colour), .req_hit(req_hit), .req_multi_hit(req_multi_hit),
      .meta_user(meta_user), .meta_drop(meta_drop), .meta_stream(meta_stream),
      .mem_word(mem_word), .seq_num(seq_num), .hdr_valid(hdr_valid), .hdr_data(hdr_data),
      .hdr_last(hdr_last), .req_ready(req_ready), .req_refused(req_refused));
   crh_host_reader crh_host_reader_inst (.pclk(pclk), .presetn(presetn), .clr(clr),
      .hdr_valid(hdr_valid), .hdr_data(hdr_data), .hdr_last(hdr_last), .words(words),
      .nw(nw), .got(got), .chain_ok(chain_ok), .payload(payload));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic report_and_stop;
      $display("Errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   function automatic logic [15:0] pay_of(input logic [6:0] c);
      return {9'h000, c} + 16'h0010;
   endfunction : pay_of
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20)
         error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // The host is cleared while the request waits, so only this record's words are kept.
   task automatic send(input logic [6:0] c, input logic h, input logic m);
      int n = 0;
      req_code <= c;
      req_payload_len <= pay_of(c);
      req_loss_counter_field <= 16'h1100 + {9'h000, c};
      req_colour <= 16'h2200 + {9'h000, c};
      req_hit <= h;
      req_multi_hit <= m;
      req_valid <= 1'b1;
      clr <= 1'b1;
      @(posedge pclk);
      while (req_ready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      req_valid <= 1'b0;
      clr <= 1'b0;
      ref_seen = 1'b0;
      // The first look comes one edge after the take, once the clear has emptied the reader.
      do
      begin
         @(posedge pclk);
         n++;
         ref_seen = (req_refused === 1'b1);
      end
      while (ref_seen == 1'b0 && got !== 1'b1 && n < 40);
      if (n >= 40)
         error_cnt++;
   endtask : send
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, CTRL_ADDR, 32'h0);
      `CHK("ctrl reset", CTRL_RESET, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      foreach (codes[i])
      begin
         send(codes[i], 1'b0, 1'b0);
         src = codes[i] inside {7'h0A, 7'h0B, 7'h0F, 7'h10, 7'h11, 7'h13, 7'h14};
         `CHK("words", 5'h02, nw)
         `CHK("type", {1'b0, codes[i]}, words[0][7:0])
         `CHK("rlen", pay_of(codes[i]) + 16'h0010, words[1][31:16])
         `CHK("lctr", (src ? 16'h2200 : 16'h1100) + codes[i], words[1][15:0])
      end
      for (int r = 32; r < 48; r += 15)
      begin
         send(7'(r), 1'b0, 1'b0);
         `CHK("refused", 1'b1, ref_seen)
         repeat (3) @(posedge pclk);
         `CHK("no words", 5'h00, nw)
      end
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, CTRL_ADDR, cv[k]);
         apb(1'b0, CTRL_ADDR, 32'h0);
         `CHK("ctrl", cv[k], rd)
         send(INFINIBAND_CODE, hv[k], hv[k]);
         src = cv[k][CTRL_SRC_BIT] & hv[k];
         cls = {1'b0, CLASSIFY_HDR_CODE, hv[k], hv[k], 2'b00, src ? mem_word[19:4] : meta_user,
            1'b0, src ? mem_word[2] : meta_drop, src ? mem_word[1:0] : meta_stream,
            cv[k][CTRL_SEQ_BIT] ? seq_num : 32'h0};
         `CHK("words", 5'h03 + {1'b0, cv[k][5:2]}, nw)
         `CHK("type", {1'b1, INFINIBAND_CODE}, words[0][7:0])
         `CHK("chain", 1'b1, chain_ok)
         `CHK("payload", pay_of(INFINIBAND_CODE), payload)
         `CHK("class", cls, words[nw - 5'h01])
      end
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("last code", INFINIBAND_CODE, rd[6:0])
      `CHK("refused count", 16'h0002, rd[31:16])
      send(ETHERNET_RECORD_CODE, 1'b0, 1'b0);
      `CHK("pad words", 5'h11, nw)
      `CHK("pad type", {1'b1, ETHERNET_RECORD_CODE}, words[0][7:0])
      `CHK("pad chain", 1'b1, chain_ok)
      `CHK("pad last more", 1'b0, words[16][CH_MORE])
      `CHK("pad rlen", pay_of(ETHERNET_RECORD_CODE) + 16'h0088, words[1][31:16])
      `CHK("pad payload", pay_of(ETHERNET_RECORD_CODE), payload)
      apb(1'b1, COUNT_ADDR, 32'hFFFFFFFF);
      `CHK("count write err", 1'b0, err)
      apb(1'b0, COUNT_ADDR, 32'h0);
      `CHK("records", 32'h0000001A, rd)
      report_and_stop();
   end
endmodule : capture_record_header_chain_tb_top
